// ### hw/dtmf_transceiver_regs.vh
// constants for the tone-pair transceiver digital core
`ifndef DTMF_TRANSCEIVER_REGS_VH
`define DTMF_TRANSCEIVER_REGS_VH

// ----------------------------------------
// time base
// ----------------------------------------
`define TB_HZ 3579545
`define MS_PER_S 1000

// ----------------------------------------
// receive timing, milliseconds
// ----------------------------------------
`define TONE_ACCEPT_MS 40
`define PAUSE_ACCEPT_MS 40
`define RX_CNT_W 18

// ----------------------------------------
// tone synthesis
// ----------------------------------------
`define ACC_W 24
`define INC_W 16
// tone frequencies in hertz, sized to the increment helper's input
`define LOW_F0 12'h2B9
`define LOW_F1 12'h2BC
`define LOW_F2 12'h354
`define LOW_F3 12'h3AD
`define HIGH_F0 12'h4B9
`define HIGH_F1 12'h538
`define HIGH_F2 12'h5C5
`define HIGH_F3 12'h661

// ----------------------------------------
// digit codes outside 1..9
// ----------------------------------------
`define CODE_ZERO 4'hA
`define CODE_STAR 4'hB
`define CODE_HASH 4'hC
`define CODE_A 4'hD
`define CODE_B 4'hE
`define CODE_C 4'hF
`define CODE_D 4'h0

// ----------------------------------------
// input synchroniser bundle
// ----------------------------------------
`define SYNC_W 18
// enable-bar starts high so the code pins stay released through reset
`define RST_VEC 18'h00100

`endif

// ### hw/tone_nco.v
// phase accumulator producing one square-wave tone
`timescale 1ns/100ps
`include "dtmf_transceiver_regs.vh"

module tone_nco
#(
   parameter ACC_W = `ACC_W,
   parameter INC_W = `INC_W
)
(
   // clock and reset
   input wire clk,
   input wire rst_b,
   // control
   input wire tick,
   input wire run,
   input wire [INC_W-1:0] increment,
   // tone
   output reg toneOut
);

   reg [ACC_W-1:0] phase_q;
   wire [ACC_W-1:0] phase_d;

   // phase restarts at zero so every burst begins on the same edge
   assign phase_d = !run ? {ACC_W{1'b0}} :
                    tick ? phase_q + {{(ACC_W-INC_W){1'b0}}, increment} : phase_q;

   // ----------------------------------------
   // accumulator and output flop
   // ----------------------------------------
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         phase_q <= {ACC_W{1'b0}};
         toneOut <= 1'b0;
      end
      else
      begin
         phase_q <= phase_d;
         toneOut <= run & phase_q[ACC_W-1];
      end
   end

endmodule

// ### hw/dtmf_transceiver_digital.v
// digital core of a tone-pair transceiver: receive timing and tone generation
`timescale 1ns/100ps
`include "dtmf_transceiver_regs.vh"

module dtmf_transceiver_digital
#(
   parameter TONE_ACCEPT_TICKS = (`TONE_ACCEPT_MS * `TB_HZ + `MS_PER_S - 1) / `MS_PER_S,
   parameter PAUSE_ACCEPT_TICKS = (`PAUSE_ACCEPT_MS * `TB_HZ + `MS_PER_S - 1) / `MS_PER_S
)
(
   // clock and reset
   input wire clk,
   input wire rst_b,
   // time base pins
   input wire crystal_input,
   output wire crystal_drive,
   input wire oscillator_select,
   input wire shared_timebase_pin_in,
   output reg shared_timebase_pin_out,
   output wire shared_timebase_pin_oe,
   // tone detectors
   input wire [3:0] lowToneDetect,
   input wire [3:0] highToneDetect,
   // receive outputs
   input wire outputEnable_b,
   output reg [3:0] rx_digit_code,
   output wire rx_digit_code_oe,
   output reg digit_valid_flag,
   // generator inputs
   input wire [3:0] tx_digit_code,
   input wire latchStrobe,
   input wire generatorReset,
   // tone outputs
   output wire lowToneOut,
   output wire highToneOut,
   output reg toneActive
);

   localparam RX_IDLE = 3'h1;
   localparam RX_QUAL = 3'h2;
   localparam RX_HELD = 3'h4;
   localparam [63:0] TB64 = `TB_HZ;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // tone increment per time-base tick, rounded to nearest
   function [`INC_W-1:0] incOf;
      input [11:0] freq;
      reg [63:0] wide;
      begin
         wide = (({52'h0, freq} << `ACC_W) + (TB64 >> 1)) / TB64;
         incOf = wide[`INC_W-1:0];
      end
   endfunction

   // matrix position to digit code, one nibble per {row, col}
   localparam [63:0] CODE_TABLE = {`CODE_D, `CODE_HASH, `CODE_ZERO, `CODE_STAR, `CODE_C, 4'h9, 4'h8, 4'h7,
                                   `CODE_B, 4'h6, 4'h5, 4'h4, `CODE_A, 4'h3, 4'h2, 4'h1};
   function [3:0] codeOf;
      input [3:0] rowCol;
      codeOf = CODE_TABLE[{rowCol, 2'b00} +: 4];
   endfunction

   // digit code to matrix position {row, col}
   function [3:0] rowColOf;
      input [3:0] code;
      integer i;
      begin
         rowColOf = 4'hF;
         for (i = 0; i < 16; i = i + 1)
            if (codeOf(i[3:0]) == code)
               rowColOf = i[3:0];
      end
   endfunction

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   reg [`SYNC_W-1:0] syncA_q, syncB_q, syncC_q, clean_q;
   wire [`SYNC_W-1:0] rawPins;
   wire [`SYNC_W-1:0] agree;

   assign rawPins = {crystal_input, shared_timebase_pin_in, oscillator_select, latchStrobe, generatorReset,
                     tx_digit_code, outputEnable_b, lowToneDetect, highToneDetect};
   assign agree = ~(syncB_q ^ syncC_q);

   // three stages, a bit changes once stages two and three agree
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         syncA_q <= `RST_VEC;
         syncB_q <= `RST_VEC;
         syncC_q <= `RST_VEC;
         clean_q <= `RST_VEC;
      end
      else
      begin
         syncA_q <= rawPins;
         syncB_q <= syncA_q;
         syncC_q <= syncB_q;
         clean_q <= (agree & syncC_q) | (~agree & clean_q);
      end
   end

   wire xtalC = clean_q[17];
   wire sharedC = clean_q[16];
   wire oscSelC = clean_q[15];
   wire latchC = clean_q[14];
   wire genRstC = clean_q[13];
   wire [3:0] txCodeC = clean_q[12:9];
   wire outEnC_b = clean_q[8];
   wire [3:0] lowC = clean_q[7:4];
   wire [3:0] highC = clean_q[3:0];

   // ----------------------------------------
   // time base selection
   // ----------------------------------------
   reg tbPrev_q;
   reg latchPrev_q;
   wire tbSrc;
   wire tick;

   assign crystal_drive = oscillator_select & ~crystal_input;
   assign shared_timebase_pin_oe = oscSelC;
   assign tbSrc = oscSelC ? xtalC : sharedC;
   assign tick = tbSrc & ~tbPrev_q;

   // edge memories and time-base repeat onto the shared pin
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tbPrev_q <= 1'b0;
         latchPrev_q <= 1'b0;
         shared_timebase_pin_out <= 1'b0;
      end
      else
      begin
         tbPrev_q <= tbSrc;
         latchPrev_q <= latchC;
         shared_timebase_pin_out <= xtalC;
      end
   end

   // ----------------------------------------
   // receive post-processor
   // ----------------------------------------
   reg [2:0] rxState_q;
   reg [`RX_CNT_W-1:0] rxCnt_q;
   reg [3:0] candCode_q;
   wire lowOne = (lowC != 4'h0) && ((lowC & (lowC - 4'h1)) == 4'h0);
   wire highOne = (highC != 4'h0) && ((highC & (highC - 4'h1)) == 4'h0);
   wire [1:0] lowIdx = {lowC[3] | lowC[2], lowC[3] | lowC[1]};
   wire [1:0] highIdx = {highC[3] | highC[2], highC[3] | highC[1]};
   wire pairValid = lowOne & highOne;
   wire [3:0] pairCode = codeOf({lowIdx, highIdx});

   assign rx_digit_code_oe = ~outEnC_b;

   // accept timer then pause timer; short gaps are bridged while held
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rxState_q <= RX_IDLE;
         rxCnt_q <= {`RX_CNT_W{1'b0}};
         candCode_q <= 4'h0;
         rx_digit_code <= 4'h0;
         digit_valid_flag <= 1'b0;
      end
      else
      begin
         case (rxState_q)
            RX_IDLE:
            begin
               rxCnt_q <= {`RX_CNT_W{1'b0}};
               if (pairValid)
               begin
                  candCode_q <= pairCode;
                  rxState_q <= RX_QUAL;
               end
            end
            RX_QUAL:
            begin
               if (!pairValid || pairCode != candCode_q)
                  rxState_q <= RX_IDLE;
               else if (tick)
               begin
                  if (rxCnt_q == TONE_ACCEPT_TICKS[`RX_CNT_W-1:0] - 1'b1)
                  begin
                     rx_digit_code <= candCode_q;
                     digit_valid_flag <= 1'b1;
                     rxCnt_q <= {`RX_CNT_W{1'b0}};
                     rxState_q <= RX_HELD;
                  end
                  else
                     rxCnt_q <= rxCnt_q + 1'b1;
               end
            end
            RX_HELD:
            begin
               if (pairValid)
                  rxCnt_q <= {`RX_CNT_W{1'b0}};
               else if (tick)
               begin
                  if (rxCnt_q == PAUSE_ACCEPT_TICKS[`RX_CNT_W-1:0] - 1'b1)
                  begin
                     rx_digit_code <= 4'h0;
                     digit_valid_flag <= 1'b0;
                     rxState_q <= RX_IDLE;
                  end
                  else
                     rxCnt_q <= rxCnt_q + 1'b1;
               end
            end
            default:
               rxState_q <= RX_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // generator control
   // ----------------------------------------
   reg [3:0] txRowCol_q;
   wire latchFall = latchPrev_q & ~latchC;

   // reset outranks a strobe in the same cycle and holds tones off
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         toneActive <= 1'b0;
         txRowCol_q <= 4'h0;
      end
      else if (genRstC)
         toneActive <= 1'b0;
      else if (latchFall)
      begin
         txRowCol_q <= rowColOf(txCodeC);
         toneActive <= 1'b1;
      end
   end

   // ----------------------------------------
   // tone synthesis
   // ----------------------------------------
   wire [1:0] toneBits;
   genvar g;

   generate
      for (g = 0; g < 2; g = g + 1)
      begin : gTone
         wire [1:0] sel = (g == 0) ? txRowCol_q[3:2] : txRowCol_q[1:0];
         wire [`INC_W-1:0] inc;
         // low group from the row, high group from the column
         assign inc = (g == 0) ?
            ((sel == 2'h0) ? incOf(`LOW_F0) : (sel == 2'h1) ? incOf(`LOW_F1) :
             (sel == 2'h2) ? incOf(`LOW_F2) : incOf(`LOW_F3)) :
            ((sel == 2'h0) ? incOf(`HIGH_F0) : (sel == 2'h1) ? incOf(`HIGH_F1) :
             (sel == 2'h2) ? incOf(`HIGH_F2) : incOf(`HIGH_F3));
         tone_nco uNco
         (
            .clk(clk),
            .rst_b(rst_b),
            .tick(tick),
            .run(toneActive),
            .increment(inc),
            .toneOut(toneBits[g])
         );
      end
   endgenerate

   assign lowToneOut = toneBits[0];
   assign highToneOut = toneBits[1];

endmodule

// ### hw/dummy_unused_placeholder_never.v
// intentionally empty of logic: no module
`timescale 1ns/100ps

// ### dv/dtmf_transceiver_digital_asserts.sv
// assertion checker and covers for the tone-pair transceiver core
`timescale 1ns/100ps
module dtmf_transceiver_digital_asserts
#(
   parameter TONE_ACCEPT_TICKS = 8,
   parameter PAUSE_ACCEPT_TICKS = 8
)
(
   // clock and reset
   input wire clk,
   input wire rst_b,
   // time base
   input wire crystal_input,
   input wire crystal_drive,
   input wire oscillator_select,
   input wire shared_timebase_pin_oe,
   input wire shared_timebase_pin_out,
   // receive side
   input wire [3:0] lowToneDetect,
   input wire [3:0] highToneDetect,
   input wire outputEnable_b,
   input wire [3:0] rx_digit_code,
   input wire rx_digit_code_oe,
   input wire digit_valid_flag,
   // generator side
   input wire latchStrobe,
   input wire generatorReset,
   input wire toneActive
);
   // ticks are at least eight clocks apart, so clocks bound each span
   localparam int TONE_MIN = (TONE_ACCEPT_TICKS - 1) * 8;
   localparam int PAUSE_MIN = (PAUSE_ACCEPT_TICKS - 1) * 8;
   wire pairOk = $onehot(lowToneDetect) && $onehot(highToneDetect);
   reg [7:0] lastPair_q;
   reg [15:0] pairRun_q;
   reg [15:0] gapRun_q;

   // ------
   // run counters
   // ------
   // saturating, so a long idle spell cannot wrap
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lastPair_q <= 8'h00;
         pairRun_q <= 16'h0000;
         gapRun_q <= 16'h0000;
      end
      else
      begin
         lastPair_q <= {lowToneDetect, highToneDetect};
         pairRun_q <= (pairOk && lastPair_q == {lowToneDetect, highToneDetect})
            ? pairRun_q + {15'h0000, ~&pairRun_q} : 16'h0000;
         gapRun_q <= pairOk ? 16'h0000 : gapRun_q + {15'h0000, ~&gapRun_q};
      end
   end

   // ------
   // properties
   // ------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   drive_pin_a: assert property (crystal_drive == (oscillator_select & ~crystal_input))
      else $error("crystal drive wrong");
   pin_repeat_a: assert property ($past(rst_b, 6) && ($past(crystal_input, 6) == $past(crystal_input, 5))
      |-> shared_timebase_pin_out == $past(crystal_input, 5))
      else $error("shared pin not repeating crystal");
   pin_release_a: assert property (!oscillator_select [*8] |-> !shared_timebase_pin_oe)
      else $error("shared pin still driven");
   code_drive_a: assert property (!outputEnable_b [*8] |-> rx_digit_code_oe)
      else $error("code not driven");
   code_float_a: assert property (outputEnable_b [*8] |-> !rx_digit_code_oe)
      else $error("code not released");
   accept_time_a: assert property ($rose(digit_valid_flag) |-> pairRun_q >= TONE_MIN)
      else $error("digit accepted too early");
   pause_time_a: assert property ($fell(digit_valid_flag) |-> gapRun_q >= PAUSE_MIN && rx_digit_code == 4'h0)
      else $error("digit cleared wrongly");
   code_hold_a: assert property (digit_valid_flag && $past(digit_valid_flag) |-> $stable(rx_digit_code))
      else $error("code moved while valid");
   tone_stop_a: assert property (generatorReset [*8] |-> !toneActive)
      else $error("tones not stopped");
   tone_start_a: assert property (!generatorReset [*8] ##1 ($fell(latchStrobe) && !generatorReset)
      |-> ##[4:8] toneActive)
      else $error("tones not started");

   accept_c: cover property ($rose(digit_valid_flag));
   start_c: cover property ($rose(toneActive));
   release_c: cover property ($fell(shared_timebase_pin_oe));
endmodule

bind dtmf_transceiver_digital dtmf_transceiver_digital_asserts #(.TONE_ACCEPT_TICKS(TONE_ACCEPT_TICKS),
   .PAUSE_ACCEPT_TICKS(PAUSE_ACCEPT_TICKS)) chk (.clk, .rst_b, .crystal_input, .crystal_drive,
   .oscillator_select, .shared_timebase_pin_oe, .shared_timebase_pin_out, .lowToneDetect, .highToneDetect,
   .outputEnable_b,
   .rx_digit_code, .rx_digit_code_oe, .digit_valid_flag, .latchStrobe, .generatorReset, .toneActive);

// ### dv/dial_ctrl_model.sv
// dialing controller model driving the generator inputs
`timescale 1ns/100ps
module dial_ctrl_model
(
   // clock and reset
   input wire clk,
   input wire rst_b,
   // requests
   input wire dialGo,
   input wire [3:0] dialCode,
   // generator pins
   output reg [3:0] tx_digit_code,
   output wire latchStrobe,
   output wire busy
);
   reg [3:0] step_q;
   assign busy = step_q != 4'h0;
   // strobe low on steps 7..12: code stands six clocks before the fall and two after the rise
   assign latchStrobe = !(step_q > 4'h6 && step_q < 4'hD);
   // any column is sent; the fourth only when the bench asks for it
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         step_q <= 4'h0;
         tx_digit_code <= 4'h0;
      end
      else
      begin
         step_q <= (step_q == 4'hE) ? 4'h0 : (busy || dialGo) ? step_q + 4'h1 : step_q;
         if (dialGo && !busy)
            tx_digit_code <= dialCode;
         if (step_q == 4'hE)
            tx_digit_code <= ~tx_digit_code; // invert after the strobe: no stale value
      end
   end
endmodule

// ### dv/tb_top.sv
// self-checking bench for the tone-pair transceiver core
`timescale 1ns/100ps
module tb_top;
   reg clk = 1'b0;
   reg rst_b = 1'b0;
   reg oscillator_select = 1'b1;
   reg crystal_input = 1'b0;
   reg extWave = 1'b0;
   reg outputEnable_b = 1'b0;
   reg generatorReset = 1'b0;
   reg dialGo = 1'b0;
   reg [3:0] dialCode = 4'h0;
   reg [3:0] lowToneDetect = 4'h0;
   reg [3:0] highToneDetect = 4'h0;
   reg [3:0] tbCnt = 4'h0;
   wire pinOut, pinOe, dialBusy, latchStrobe, crystal_drive, rx_digit_code_oe, digit_valid_flag;
   wire lowToneOut, highToneOut, toneActive;
   wire [3:0] tx_digit_code, rx_digit_code;
   wire pinWire = pinOe ? pinOut : extWave;
   integer errTotal = 0, checksDone = 0, seed = 24801, k;
   int expQ[$];

   dtmf_transceiver_digital #(.TONE_ACCEPT_TICKS(8), .PAUSE_ACCEPT_TICKS(8)) dut (.clk, .rst_b, .crystal_input,
      .crystal_drive, .oscillator_select, .shared_timebase_pin_in(pinWire), .shared_timebase_pin_out(pinOut),
      .shared_timebase_pin_oe(pinOe), .lowToneDetect, .highToneDetect, .outputEnable_b, .rx_digit_code,
      .rx_digit_code_oe, .digit_valid_flag, .tx_digit_code, .latchStrobe, .generatorReset, .lowToneOut,
      .highToneOut, .toneActive);
   dial_ctrl_model partner (.clk, .rst_b, .dialGo, .dialCode, .tx_digit_code, .latchStrobe, .busy(dialBusy));

   always #25 clk = ~clk;
   // scaled time base, a tick every 16 clocks; crystal tied high when unused
   always @(posedge clk)
   begin
      tbCnt <= tbCnt + 4'h1;
      crystal_input <= oscillator_select ? tbCnt[3] : 1'b1;
      extWave <= tbCnt[3];
   end

   // matrix model: 1..9, then fourth column and bottom row
   function integer codeOf(input integer r, input integer c);
      codeOf = (c == 3) ? ((r == 3) ? 0 : 13 + r) : (r == 3) ? ((c == 0) ? 11 : (c == 1) ? 10 : 12) : r * 3 + c + 1;
   endfunction

   task check(input string nm, input [4:0] e, input [4:0] g);
   begin
      checksDone = checksDone + 1;
      if (g !== e)
      begin
         errTotal = errTotal + 1;
         $display("ERROR %0s expected %h seen %h", nm, e, g);
      end
   end
   endtask

   // hold a pair n clocks, compare, then pause past acceptance
   task rx(input integer r, input integer c, input integer n);
      integer e;
   begin
      @(posedge clk);
      lowToneDetect <= 4'h1 << r;
      highToneDetect <= 4'h1 << c;
      repeat (n) @(posedge clk);
      if (n > 160)
         expQ.push_back(codeOf(r, c));
      e = (expQ.size() > 0) ? expQ.pop_front() : 0;
      @(negedge clk);
      check("valid", n > 160, digit_valid_flag);
      check("code", e, rx_digit_code);
      @(posedge clk);
      lowToneDetect <= 4'h0;
      highToneDetect <= 4'h0;
      repeat (200) @(negedge clk);
      check("cleared", 0, {digit_valid_flag, rx_digit_code});
   end
   endtask

   task dial(input [3:0] code, input [4:0] exp);
      integer n;
   begin
      @(posedge clk);
      dialCode <= code;
      dialGo <= 1'b1;
      @(posedge clk);
      dialGo <= 1'b0;
      @(negedge clk);
      for (n = 0; n < 40 && dialBusy !== 1'b0; n = n + 1)
         @(negedge clk);
      check("toneOn", exp, toneActive);
   end
   endtask

   task conclude;
   begin
      if (errTotal == 0 && checksDone > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask

   initial
   begin
      repeat (40000) @(posedge clk);
      errTotal = errTotal + 1;
      conclude;
   end

   initial
   begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      for (k = 0; k < 16; k = k + 1)
         rx(k / 4, k % 4, 180 + ($random(seed) & 31));
      rx(2, 1, 64);
      @(posedge clk);
      oscillator_select <= 1'b0;
      outputEnable_b <= 1'b1;
      repeat (10) @(negedge clk);
      check("pinOe", 0, pinOe);
      check("codeOe", 0, rx_digit_code_oe);
      rx(1, 2, 200);
      for (k = 0; k < 16; k = k + 1)
         dial(k, 1);
      @(posedge clk);
      generatorReset <= 1'b1;
      repeat (10) @(negedge clk);
      check("stopped", 0, {toneActive, lowToneOut, highToneOut});
      dial($random(seed), 0);
      @(posedge clk);
      generatorReset <= 1'b0;
      repeat (12) @(negedge clk);
      check("stayOff", 0, toneActive);
      dial($random(seed), 1);
      conclude;
   end
endmodule
